/* File: design/fcsm_pkg.sv */
/*
 fcsm_pkg: constants and types shared by both ends of the cyclic slot map link.
 assumes both ends run on one 10 MHz clock, sys_clk.
*/
// Operation
// R1: full-function or profile mode, chosen by local setting
// R2: profile mode offers only flow input and totalizer
// R3: identity depends on variant, profile shares one
// R4: fixed slot positions, master configures in order
// R5: slots 1-3 analog inputs, default flow/volume/temperature
// R6: slots 4-5 three totalizer variants, mass default
// R7: slots 6-9 display, control, pressure, analyzer
// R8: filler module fills gaps, carries no data
// R9: new configuration applies only after device reset
// R10: channel setting reassigns measured variable per block
// R11: non-volatile change written, endurance one million
// R12: master avoids continuous non-volatile writes
// R13: master configures only modules it uses
// R14: input modules give float then status byte
// R15: control byte: 0 totalize, 1 clear, 2 preset
// R16: mismatched configuration refused, no exchange until valid
package fcsm_pkg;
    localparam int NSLOT = 9;
    typedef enum logic [3:0] {
        FCSM_EMPTY, FCSM_ANALOG_INPUT, FCSM_TOT, FCSM_TOT_CTL, FCSM_TOT_CTL_CFG,
        FCSM_DISPLAY, FCSM_CONTROL, FCSM_PRESSURE, FCSM_ANALYZER
    } fcsm_type_e;
    // channel identifiers of the measured variables
    localparam logic [8:0] CH_OFF = 9'h000;
    localparam logic [8:0] CH_MASS = 9'h115;
    localparam logic [8:0] CH_CORR_VOL = 9'h18E;
    localparam logic [8:0] CH_TEMP = 9'h11D;
    localparam logic [7:0] ST_GOOD = 8'h80;
    localparam logic [7:0] TC_TOTALIZE = 8'h00;
    localparam logic [7:0] TC_CLEAR = 8'h01;
    localparam logic [7:0] TC_PRESET = 8'h02;
    localparam logic [7:0] TM_STOP = 8'h03;
    localparam int NV_LIMIT = 1000000;
    localparam logic [19:0] NV_LIMIT_CNT = 20'(NV_LIMIT);
    // identity codes: values are arbitrary
    localparam logic [15:0] ID_FULL_A = 16'hA001;
    localparam logic [15:0] ID_FULL_B = 16'hA002;
    localparam logic [15:0] ID_PROFILE = 16'hA0F0;
    // register byte offsets of the controller
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_CFG_LO = 5'h04;
    localparam logic [4:0] REG_CFG_HI = 5'h08;
    localparam logic [4:0] REG_STATUS = 5'h0C;
    localparam logic [4:0] REG_RDATA = 5'h10;
    localparam logic [4:0] REG_RSTAT = 5'h14;
    // field positions
    localparam int CTRL_SEND = 0;
    localparam int CTRL_XFER = 1;
    localparam int CTRL_SLOT = 4;
    localparam int CTRL_TCTL = 8;
    localparam int CTRL_TCFG = 16;
    localparam int HI_COUNT = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_ACK = 1;
    localparam int ST_NAK = 2;
    localparam int ST_XERR = 3;
    localparam int ST_XDONE = 4;
    localparam int ST_IDENT = 16;
endpackage

/* File: design/fcsm_if.sv */
/*
 fcsm_if: link between the slot map device and its master controller.
 assumes both ends share sys_clk; no clocking block.
*/
`timescale 1ns/100ps
interface fcsm_if;
    logic cfg_valid;
    logic [3:0] cfg_type;
    logic cfg_last;
    logic cfg_ready;
    logic cfg_ack;
    logic cfg_nak;
    logic [15:0] ident;
    logic xfer_valid;
    logic [3:0] xfer_slot;
    logic [7:0] xfer_ctl;
    logic [7:0] xfer_cfg;
    logic rsp_valid;
    logic rsp_err;
    logic [39:0] rsp_data;
    modport dev (input cfg_valid, cfg_type, cfg_last, xfer_valid, xfer_slot, xfer_ctl, xfer_cfg,
                 output cfg_ready, cfg_ack, cfg_nak, ident, rsp_valid, rsp_err, rsp_data);
    modport ctl (output cfg_valid, cfg_type, cfg_last, xfer_valid, xfer_slot, xfer_ctl, xfer_cfg,
                 input cfg_ready, cfg_ack, cfg_nak, ident, rsp_valid, rsp_err, rsp_data);
endinterface

/* File: design/fcsm_device.sv */
/*
 fcsm_device: slave end; checks the module layout, applies it on restart,
 answers cyclic exchanges and drives totalizer controls.
 assumes link signals come from logic on sys_clk; local pins are asynchronous.
*/
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module fcsm_device (
    input wire logic sys_clk,
    input wire logic rstn,
    fcsm_if.dev link,
    input wire logic full_function_mode,
    input wire logic variant_b,
    input wire logic restart,
    input wire logic [31:0] mass_flow,
    input wire logic [31:0] corr_vol_flow,
    input wire logic [31:0] temperature,
    input wire logic [31:0] pressure,
    input wire logic [31:0] analyzer_a,
    input wire logic [31:0] tot_mass,
    input wire logic [31:0] tot_corr_vol,
    input wire logic [2:0][8:0] chan_analog_input,
    input wire logic [1:0][8:0] chan_tot,
    output logic [1:0] tot_clear,
    output logic [1:0] tot_preset,
    output logic [1:0] tot_hold,
    output logic [1:0][7:0] totalizer_config_byte,
    output logic nv_write,
    output logic nv_worn,
    output logic cfg_active
);
    typedef struct packed {
        logic mode_s1;
        logic mode_s2;
        logic var_s1;
        logic var_s2;
        logic rst_s1;
        logic rst_s2;
        logic rst_d;
        logic [3:0] idx;
        logic bad;
        logic [fcsm_pkg::NSLOT-1:0][3:0] pend;
        logic [fcsm_pkg::NSLOT-1:0][3:0] act;
        logic pend_ok;
        logic act_ok;
        logic act_full;
        logic cfg_ready;
        logic cfg_ack;
        logic cfg_nak;
        logic [15:0] ident;
        logic rsp_valid;
        logic rsp_err;
        logic [39:0] rsp_data;
        logic [1:0] tot_clear;
        logic [1:0] tot_preset;
        logic [1:0][7:0] tot_cfg;
        logic [1:0] tot_hold;
        logic nv_write;
        logic [19:0] nv_count;
        logic nv_worn;
    } fcsm_dev_s;

    fcsm_dev_s r;
    fcsm_dev_s next_r;

    // slot is 1-based; filler is legal anywhere
    function automatic logic fcsm_legal(input logic full, input logic [3:0] slot, input logic [3:0] t);
        fcsm_legal = 1'b0;
        if (t == fcsm_pkg::FCSM_EMPTY) begin
            fcsm_legal = 1'b1; // see R8
        end else if (!full) begin
            // see R2
            fcsm_legal = (slot == 4'h1 && t == fcsm_pkg::FCSM_ANALOG_INPUT)
                || (slot == 4'h2 && t == fcsm_pkg::FCSM_TOT);
        end else begin
            case (slot)
                4'h1, 4'h2, 4'h3: fcsm_legal = (t == fcsm_pkg::FCSM_ANALOG_INPUT); // see R5
                4'h4, 4'h5: fcsm_legal = (t == fcsm_pkg::FCSM_TOT) || (t == fcsm_pkg::FCSM_TOT_CTL)
                    || (t == fcsm_pkg::FCSM_TOT_CTL_CFG); // see R6
                4'h6: fcsm_legal = (t == fcsm_pkg::FCSM_DISPLAY); // see R7
                4'h7: fcsm_legal = (t == fcsm_pkg::FCSM_CONTROL);
                4'h8: fcsm_legal = (t == fcsm_pkg::FCSM_PRESSURE);
                4'h9: fcsm_legal = (t == fcsm_pkg::FCSM_ANALYZER);
                default: fcsm_legal = 1'b0;
            endcase
        end
    endfunction

    // see R10
    function automatic logic [31:0] fcsm_pick(input logic [8:0] ch, input logic [31:0] m, input logic [31:0] v,
                                             input logic [31:0] t);
        case (ch)
            fcsm_pkg::CH_MASS: fcsm_pick = m;
            fcsm_pkg::CH_CORR_VOL: fcsm_pick = v;
            fcsm_pkg::CH_TEMP: fcsm_pick = t;
            default: fcsm_pick = 32'h00000000;
        endcase
    endfunction

    always_comb begin
        logic [3:0] t;
        logic [3:0] s;
        logic [31:0] val;
        next_r = r;
        t = 4'h0;
        s = 4'h0;
        val = 32'h00000000;
        next_r.mode_s1 = full_function_mode;
        next_r.mode_s2 = r.mode_s1;
        next_r.var_s1 = variant_b;
        next_r.var_s2 = r.var_s1;
        next_r.rst_s1 = restart;
        next_r.rst_s2 = r.rst_s1;
        next_r.rst_d = r.rst_s2;
        next_r.cfg_ack = 1'b0;
        next_r.cfg_nak = 1'b0;
        next_r.rsp_valid = 1'b0;
        next_r.rsp_err = 1'b0;
        next_r.tot_clear = 2'b00;
        next_r.tot_preset = 2'b00;
        next_r.nv_write = 1'b0;
        next_r.cfg_ready = 1'b1;
        // see R1 see R3
        if (!r.mode_s2) begin
            next_r.ident = fcsm_pkg::ID_PROFILE;
        end else if (r.var_s2) begin
            next_r.ident = fcsm_pkg::ID_FULL_B;
        end else begin
            next_r.ident = fcsm_pkg::ID_FULL_A;
        end

        // layout stream: one type per slot, slot 1 first
        if (link.cfg_valid && r.cfg_ready) begin
            s = r.idx + 4'h1; // see R4
            if (32'(s) > fcsm_pkg::NSLOT || !fcsm_legal(r.mode_s2, s, link.cfg_type)) begin
                next_r.bad = 1'b1; // see R16
            end else begin
                next_r.pend[r.idx] = link.cfg_type;
            end
            next_r.idx = s;
            if (link.cfg_last) begin
                if (r.bad || 32'(s) > fcsm_pkg::NSLOT || !fcsm_legal(r.mode_s2, s, link.cfg_type)) begin
                    next_r.cfg_nak = 1'b1;
                    next_r.pend_ok = 1'b0;
                end else begin
                    next_r.cfg_ack = 1'b1;
                    next_r.pend_ok = 1'b1;
                    for (int i = 0; i < fcsm_pkg::NSLOT; i++) begin
                        if (i >= 32'(s)) begin
                            next_r.pend[i] = fcsm_pkg::FCSM_EMPTY;
                        end
                    end
                end
                next_r.idx = 4'h0;
                next_r.bad = 1'b0;
            end
        end

        // loaded layout takes effect only on a restart edge
        if (r.rst_s2 && !r.rst_d) begin
            next_r.act = r.pend; // see R9
            next_r.act_ok = r.pend_ok;
            next_r.act_full = r.mode_s2;
        end

        if (link.xfer_valid) begin
            next_r.rsp_valid = 1'b1;
            s = link.xfer_slot;
            t = (s >= 4'h1 && 32'(s) <= fcsm_pkg::NSLOT) ? r.act[s - 4'h1] : 4'h0;
            if (!r.act_ok || t == fcsm_pkg::FCSM_EMPTY) begin
                next_r.rsp_err = 1'b1; // see R16 see R8
                next_r.rsp_data = 40'h0000000000;
            end else begin
                case (t)
                    fcsm_pkg::FCSM_ANALOG_INPUT: begin
                        if (!r.act_full) begin
                            val = mass_flow; // see R2
                        end else begin
                            val = fcsm_pick(chan_analog_input[s - 4'h1], mass_flow, corr_vol_flow, temperature);
                        end
                    end
                    fcsm_pkg::FCSM_TOT, fcsm_pkg::FCSM_TOT_CTL, fcsm_pkg::FCSM_TOT_CTL_CFG: begin
                        if (!r.act_full) begin
                            val = tot_mass;
                        end else begin
                            // slot 4 is block 1 (index 0), slot 5 is block 2 (index 1)
                            val = fcsm_pick(chan_tot[s[0]], tot_mass, tot_corr_vol, 32'h00000000);
                        end
                    end
                    fcsm_pkg::FCSM_PRESSURE: val = pressure;
                    fcsm_pkg::FCSM_ANALYZER: val = analyzer_a;
                    default: val = 32'h00000000;
                endcase
                next_r.rsp_data = {val, fcsm_pkg::ST_GOOD}; // see R14
                if (t == fcsm_pkg::FCSM_TOT_CTL || t == fcsm_pkg::FCSM_TOT_CTL_CFG) begin
                    // one-shot commands; totalizing resumes by itself
                    if (link.xfer_ctl == fcsm_pkg::TC_CLEAR) begin
                        next_r.tot_clear[s[0]] = 1'b1; // see R15
                    end else if (link.xfer_ctl == fcsm_pkg::TC_PRESET) begin
                        next_r.tot_preset[s[0]] = 1'b1;
                    end
                end
                if (t == fcsm_pkg::FCSM_TOT_CTL_CFG && link.xfer_cfg != r.tot_cfg[s[0]]) begin
                    // only real changes reach the store, sparing its write life
                    next_r.tot_cfg[s[0]] = link.xfer_cfg;
                    next_r.nv_write = 1'b1; // see R11
                    if (r.nv_count != fcsm_pkg::NV_LIMIT_CNT) begin
                        next_r.nv_count = r.nv_count + 20'h00001;
                    end
                end
            end
        end
        next_r.nv_worn = (r.nv_count == fcsm_pkg::NV_LIMIT_CNT);
        next_r.tot_hold[0] = (next_r.tot_cfg[0] == fcsm_pkg::TM_STOP);
        next_r.tot_hold[1] = (next_r.tot_cfg[1] == fcsm_pkg::TM_STOP);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign link.cfg_ready = r.cfg_ready;
    assign link.cfg_ack = r.cfg_ack;
    assign link.cfg_nak = r.cfg_nak;
    assign link.ident = r.ident;
    assign link.rsp_valid = r.rsp_valid;
    assign link.rsp_err = r.rsp_err;
    assign link.rsp_data = r.rsp_data;
    assign tot_clear = r.tot_clear;
    assign tot_preset = r.tot_preset;
    assign tot_hold = r.tot_hold;
    assign totalizer_config_byte = r.tot_cfg;
    assign nv_write = r.nv_write;
    assign nv_worn = r.nv_worn;
    assign cfg_active = r.act_ok;
endmodule

/* File: design/fcsm_master.sv */
/*
 fcsm_master: master controller end; software sets the layout and starts
 transfers through Avalon-MM registers.
 assumes the device end shares sys_clk.
*/
`timescale 1ns/100ps
module fcsm_master (
    input wire logic sys_clk,
    input wire logic rstn,
    fcsm_if.ctl link,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    typedef enum logic [1:0] {M_IDLE, M_SEND, M_WAIT, M_XFER} fcsm_mst_e;
    typedef struct packed {
        fcsm_mst_e st;
        logic [31:0] rdata;
        logic [31:0] cfg_lo;
        logic [7:0] cfg_hi;
        logic [3:0] idx;
        logic [3:0] slot;
        logic [7:0] tctl;
        logic [7:0] tcfg;
        logic ack;
        logic nak;
        logic xerr;
        logic xdone;
        logic [39:0] resp;
        logic cfg_valid;
        logic [3:0] cfg_type;
        logic cfg_last;
        logic xfer_valid;
        logic waitreq;
    } fcsm_mst_s;

    fcsm_mst_s r;
    fcsm_mst_s next_r;

    always_comb begin
        logic [3:0] cnt;
        logic [35:0] types;
        next_r = r;
        cnt = r.cfg_hi[fcsm_pkg::HI_COUNT +: 4];
        types = {r.cfg_hi[3:0], r.cfg_lo};
        // one wait cycle, then the answer stands for one cycle
        next_r.waitreq = !((avs_read || avs_write) && r.waitreq);
        if ((avs_read || avs_write) && r.waitreq) begin
            case (avs_address)
                fcsm_pkg::REG_CTRL: next_r.rdata = {8'h00, r.tcfg, r.tctl, r.slot, 4'h0};
                fcsm_pkg::REG_CFG_LO: next_r.rdata = r.cfg_lo;
                fcsm_pkg::REG_CFG_HI: next_r.rdata = {24'h000000, r.cfg_hi};
                fcsm_pkg::REG_STATUS: next_r.rdata = {link.ident, 11'h000, r.xdone, r.xerr, r.nak, r.ack,
                    r.st != M_IDLE};
                fcsm_pkg::REG_RDATA: next_r.rdata = r.resp[39:8];
                fcsm_pkg::REG_RSTAT: next_r.rdata = {24'h000000, r.resp[7:0]};
                default: next_r.rdata = 32'h00000000;
            endcase
        end
        if (avs_write && !r.waitreq) begin
            case (avs_address)
                fcsm_pkg::REG_CFG_LO: next_r.cfg_lo = avs_writedata;
                fcsm_pkg::REG_CFG_HI: next_r.cfg_hi = avs_writedata[7:0];
                fcsm_pkg::REG_STATUS: begin
                    // write one to clear
                    next_r.ack = r.ack && !avs_writedata[fcsm_pkg::ST_ACK];
                    next_r.nak = r.nak && !avs_writedata[fcsm_pkg::ST_NAK];
                    next_r.xerr = r.xerr && !avs_writedata[fcsm_pkg::ST_XERR];
                    next_r.xdone = r.xdone && !avs_writedata[fcsm_pkg::ST_XDONE];
                end
                fcsm_pkg::REG_CTRL: begin
                    next_r.slot = avs_writedata[fcsm_pkg::CTRL_SLOT +: 4];
                    next_r.tctl = avs_writedata[fcsm_pkg::CTRL_TCTL +: 8];
                    next_r.tcfg = avs_writedata[fcsm_pkg::CTRL_TCFG +: 8];
                    // commands while busy are dropped
                    if (r.st == M_IDLE && avs_writedata[fcsm_pkg::CTRL_SEND] && cnt != 4'h0) begin
                        next_r.st = M_SEND; // see R4 see R13
                        next_r.idx = 4'h0;
                        next_r.cfg_valid = 1'b1;
                        next_r.cfg_type = types[3:0];
                        next_r.cfg_last = (cnt == 4'h1);
                    end else if (r.st == M_IDLE && avs_writedata[fcsm_pkg::CTRL_XFER]) begin
                        next_r.st = M_XFER;
                        next_r.xfer_valid = 1'b1;
                    end
                end
                default: next_r.st = r.st;
            endcase
        end
        case (r.st)
            M_IDLE: begin
                // a command taken above has already set the next state
            end
            M_SEND: begin
                if (link.cfg_ready) begin
                    next_r.idx = r.idx + 4'h1;
                    if (r.cfg_last) begin
                        next_r.cfg_valid = 1'b0;
                        next_r.st = M_WAIT;
                    end else begin
                        // slot order fixed; unused gaps hold the filler from software; see R8
                        next_r.cfg_type = types[4 * (r.idx + 4'h1) +: 4];
                        next_r.cfg_last = (r.idx + 4'h2 == cnt);
                    end
                end
            end
            M_WAIT: begin
                if (link.cfg_ack || link.cfg_nak) begin
                    next_r.st = M_IDLE;
                end
            end
            M_XFER: begin
                next_r.xfer_valid = 1'b0;
                if (link.rsp_valid) begin
                    next_r.resp = link.rsp_data;
                    next_r.st = M_IDLE;
                end
            end
            default: next_r.st = M_IDLE;
        endcase
        // hardware set wins over software clear
        if (r.st == M_WAIT && link.cfg_ack) begin
            next_r.ack = 1'b1;
        end
        if (r.st == M_WAIT && link.cfg_nak) begin
            next_r.nak = 1'b1;
        end
        if (r.st == M_XFER && link.rsp_valid) begin
            next_r.xdone = 1'b1;
            next_r.xerr = next_r.xerr || link.rsp_err;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            // waitreq is the lowest bit: the bus stalls through reset
            r <= fcsm_mst_s'(1'b1);
        end else begin
            r <= next_r;
        end
    end

    assign avs_waitrequest = r.waitreq;
    assign avs_readdata = r.rdata;
    assign link.cfg_valid = r.cfg_valid;
    assign link.cfg_type = r.cfg_type;
    assign link.cfg_last = r.cfg_last;
    assign link.xfer_valid = r.xfer_valid;
    assign link.xfer_slot = r.slot;
    assign link.xfer_ctl = r.tctl;
    assign link.xfer_cfg = r.tcfg;
endmodule

/* File: bench/fcsm_link_checker.sv */
/*
 fcsm_link_checker: assertions on the layout and exchange signals of the link.
 assumes one clock, sys_clk, and an asynchronous active-low rstn for both ends.
*/
`timescale 1ns/100ps
module fcsm_link_checker (
    input logic sys_clk,
    input logic rstn,
    input logic cfg_valid,
    input logic cfg_last,
    input logic cfg_ready,
    input logic cfg_ack,
    input logic cfg_nak,
    input logic xfer_valid,
    input logic rsp_valid,
    input logic rsp_err,
    input logic [39:0] rsp_data
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_last_taken;
        cfg_valid && cfg_ready && cfg_last;
    endsequence
    sequence s_answer;
        cfg_ack ^ cfg_nak;
    endsequence
    AST_LAYOUT_ANSWER: assert property (s_last_taken |=> s_answer)
        else $error("layout end not answered by one of ack or nak");
    AST_ANSWER_CAUSE: assert property ((cfg_ack || cfg_nak) |-> $past(cfg_valid && cfg_ready && cfg_last))
        else $error("layout answer without a last entry");
    AST_ANSWER_ONCE: assert property (s_last_taken ##1 s_answer |=> !cfg_ack && !cfg_nak)
        else $error("layout answer longer than one cycle");
    // first edge after release still sees the reset value
    AST_READY_UP: assert property ($past(rstn) |-> cfg_ready)
        else $error("device not ready for layout entries");
    AST_RSP_NEXT: assert property (xfer_valid |=> rsp_valid)
        else $error("exchange not answered next cycle");
    AST_RSP_CAUSE: assert property (rsp_valid |-> $past(xfer_valid))
        else $error("answer without request");
    AST_ERR_ZERO: assert property (rsp_valid && rsp_err |-> rsp_data == 40'h0)
        else $error("refused exchange carries data");
    AST_GOOD_STATUS: assert property (rsp_valid && !rsp_err |-> rsp_data[7:0] == 8'h80)
        else $error("status byte not good");
    AST_DATA_HOLDS: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("answer data changed between answers");
endmodule

/* File: bench/testbench.sv */
/*
 testbench: software side over Avalon-MM on the master, local pins on the device.
 assumes both ends meet in fcsm_if on one 10 MHz sys_clk.
*/
`timescale 1ns/100ps
module testbench;
    logic sys_clk = 0;
    logic rstn = 0;
    logic full_function_mode = 1;
    logic variant_b = 0;
    logic restart = 0;
    logic [4:0] avs_address = 0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = 0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest;
    logic [31:0] v[7] = '{32'h3F800001, 32'h3F800002, 32'h3F800003, 32'h3F800004, 32'h3F800005, 32'h3F800006,
        32'h3F800007};
    logic [2:0][8:0] chan_analog_input = {fcsm_pkg::CH_TEMP, fcsm_pkg::CH_CORR_VOL, fcsm_pkg::CH_MASS};
    logic [1:0][8:0] chan_tot = {fcsm_pkg::CH_MASS, fcsm_pkg::CH_MASS};
    logic [1:0] tot_clear, tot_preset, tot_hold;
    logic [1:0][7:0] totalizer_config_byte;
    logic nv_write, nv_worn, cfg_active;
    int err_total = 0;
    int cmp_count = 0;
    int n_clr = 0;
    int n_pre = 0;
    int n_nv = 0;
    int n_clr_b = 0;
    always #50 sys_clk = ~sys_clk;
    // pulses last one cycle, so they are counted rather than sampled later
    always @(posedge sys_clk) begin
        if (tot_clear[0] === 1'b1) n_clr++;
        if (tot_clear[1] === 1'b1) n_clr_b++;
        if (tot_preset[0] === 1'b1) n_pre++;
        if (nv_write === 1'b1) n_nv++;
    end
    fcsm_if fcsm_if_i ();
    fcsm_master fcsm_master_i (.sys_clk, .rstn, .link(fcsm_if_i), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest);
    fcsm_device fcsm_device_i (.sys_clk, .rstn, .link(fcsm_if_i), .full_function_mode, .variant_b, .restart,
        .mass_flow(v[0]), .corr_vol_flow(v[1]), .temperature(v[2]), .pressure(v[3]), .analyzer_a(v[4]),
        .tot_mass(v[5]), .tot_corr_vol(v[6]), .chan_analog_input, .chan_tot, .tot_clear, .tot_preset, .tot_hold,
        .totalizer_config_byte, .nv_write, .nv_worn, .cfg_active);
    fcsm_link_checker fcsm_link_checker_i (.sys_clk, .rstn, .cfg_valid(fcsm_if_i.cfg_valid),
        .cfg_last(fcsm_if_i.cfg_last), .cfg_ready(fcsm_if_i.cfg_ready), .cfg_ack(fcsm_if_i.cfg_ack),
        .cfg_nak(fcsm_if_i.cfg_nak), .xfer_valid(fcsm_if_i.xfer_valid), .rsp_valid(fcsm_if_i.rsp_valid),
        .rsp_err(fcsm_if_i.rsp_err), .rsp_data(fcsm_if_i.rsp_data));

    task chk(input string nm, input logic [39:0] s, input logic [39:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // request held until waitrequest is seen low, released at that same edge
    task av(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 50) err_total++;
        rd = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask
    task poll(input logic [31:0] m);
        int n;
        n = 0;
        do begin
            av(0, fcsm_pkg::REG_STATUS, 0);
            n++;
        end while ((rd & m) == 0 && n < 50);
    endtask
    task send(input logic [31:0] lo, input logic [31:0] hi, input logic [1:0] exp);
        av(1, fcsm_pkg::REG_STATUS, 32'h0000001E);
        av(1, fcsm_pkg::REG_CFG_LO, lo);
        av(1, fcsm_pkg::REG_CFG_HI, hi);
        av(1, fcsm_pkg::REG_CTRL, 32'h00000001);
        poll(32'h00000006);
        chk("layout nak,ack", rd[2:1], exp);
    endtask
    task xchk(input logic [3:0] s, input logic [7:0] ctl, input logic [7:0] cfg, input logic [31:0] e,
        input logic err);
        av(1, fcsm_pkg::REG_STATUS, 32'h0000001E);
        av(1, fcsm_pkg::REG_CTRL, {8'h00, cfg, ctl, s, 4'h2});
        poll(32'h00000018);
        chk("exchange error", rd[3], err);
        if (!err) begin
            av(0, fcsm_pkg::REG_RDATA, 0);
            chk("value", rd, e);
            av(0, fcsm_pkg::REG_RSTAT, 0);
            chk("status byte", rd[7:0], 8'h80);
        end
    endtask
    task restart_dev;
        @(posedge sys_clk);
        restart <= 1;
        repeat (5) @(posedge sys_clk);
        restart <= 0;
        repeat (8) @(posedge sys_clk);
    endtask
    task set_mode(input logic f, input logic b, input logic [15:0] id);
        @(posedge sys_clk);
        full_function_mode <= f;
        variant_b <= b;
        repeat (5) @(posedge sys_clk);
        restart_dev;
        av(0, fcsm_pkg::REG_STATUS, 0);
        chk("ident", rd[31:16], id);
    endtask
    task t_full;
        logic [31:0] e[9];
        e = '{v[0], v[1], v[2], v[5], v[5], 0, 0, v[3], v[4]};
        set_mode(1, 1, fcsm_pkg::ID_FULL_B);
        set_mode(1, 0, fcsm_pkg::ID_FULL_A);
        av(0, 5'h1C, 32'hFFFFFFFF);
        chk("unmapped read", rd, 0);
        send(32'h76543111, 32'h00000098, 2'b01);
        xchk(1, 0, 0, 0, 1);
        restart_dev;
        chk("layout active", cfg_active, 1);
        for (int i = 0; i < 9; i++) xchk(i + 1, 0, 0, e[i], 0);
        $display("t_full done");
    endtask
    task t_chan;
        @(posedge sys_clk);
        chan_analog_input[0] <= fcsm_pkg::CH_TEMP;
        chan_tot[1] <= fcsm_pkg::CH_CORR_VOL;
        xchk(1, 0, 0, v[2], 0);
        xchk(5, 0, 0, v[6], 0);
        $display("t_chan done");
    endtask
    task t_tot;
        xchk(4, fcsm_pkg::TC_CLEAR, 0, v[5], 0);
        xchk(4, fcsm_pkg::TC_CLEAR, 0, v[5], 0);
        chk("clear pulses", n_clr, 2);
        xchk(4, fcsm_pkg::TC_PRESET, 0, v[5], 0);
        xchk(4, fcsm_pkg::TC_TOTALIZE, 0, v[5], 0);
        chk("clear after preset", n_clr, 2);
        chk("preset pulses", n_pre, 1);
        xchk(5, 0, fcsm_pkg::TM_STOP, v[6], 0);
        xchk(5, 0, fcsm_pkg::TM_STOP, v[6], 0);
        chk("config byte", totalizer_config_byte[1], fcsm_pkg::TM_STOP);
        chk("hold", tot_hold[1], 1);
        chk("stored once", n_nv, 1);
        xchk(5, 0, 0, v[6], 0);
        chk("stored again", n_nv, 2);
        chk("hold off", tot_hold[1], 0);
        xchk(5, fcsm_pkg::TC_CLEAR, 0, v[6], 0);
        chk("block 2 clear", n_clr_b, 1);
        chk("block 1 untouched", n_clr, 2);
        chk("store not worn", nv_worn, 0);
        $display("t_tot done");
    endtask
    task t_layout_err;
        send(32'h00000002, 32'h00000010, 2'b10);
        send(32'h76543111, 32'h000000A8, 2'b10);
        send(32'h00000101, 32'h00000030, 2'b01);
        restart_dev;
        xchk(2, 0, 0, 0, 1);
        xchk(3, 0, 0, v[2], 0);
        $display("t_layout_err done");
    endtask
    task t_profile;
        set_mode(0, 1, fcsm_pkg::ID_PROFILE);
        send(32'h00000121, 32'h00000030, 2'b10);
        send(32'h00000021, 32'h00000020, 2'b01);
        restart_dev;
        xchk(1, 0, 0, v[0], 0);
        xchk(2, 0, 0, v[5], 0);
        xchk(3, 0, 0, 0, 1);
        $display("t_profile done");
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1;
        t_full;
        t_chan;
        t_tot;
        t_layout_err;
        t_profile;
        tally_and_finish;
    end
    // about fifteen times the expected length of the whole run
    initial begin
        #1000000;
        err_total++;
        tally_and_finish;
    end
endmodule
